/* rtl/signal_routing_crossbar.sv */
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
module signal_routing_crossbar (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire route_pkg::wb_req_t wb_req,
  output route_pkg::wb_rsp_t wb_rsp,
  input wire logic [route_pkg::PIN_COUNT-1:0] pin_buffer_out,
  input wire route_pkg::periph_src_t periph_src,
  output logic [route_pkg::FS_DESTS-1:0] frame_sync_dest,
  output logic [route_pkg::PIN_COUNT-1:0] pin_buffer_in
);
  import route_pkg::*;

  typedef struct packed {
    logic [FS_REGS-1:0][31:0] fs_word;
    logic [PIN_REGS-1:0][31:0] pin_word;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic fs_route(input logic [FS_SEL_W-1:0] code,
                                    input logic [PIN_COUNT-1:0] pins,
                                    input periph_src_t src);
    logic r;
    r = 1'h0;
    if (code <= FS_PIN_LAST) begin
      r = pins[code];
    end else if (code <= FS_SPORT_LAST) begin
      r = src.sport_fs[3'(code - FS_SPORT_FIRST)];
    end else begin
      case (code)
        FS_RX_FS: r = src.spdif_rx_framesync;
        FS_TX_BIPHASE: r = src.spdif_tx_biphase;
        FS_PCG_FS_A: r = src.precision_framesync[0];
        FS_PCG_FS_B: r = src.precision_framesync[1];
        FS_LOW: r = 1'h0;
        FS_HIGH: r = 1'h1;
        default: r = 1'h0;
      endcase
    end
    return r;
  endfunction

  // Reserved pin codes drive low so a stray value never floats a pin input.
  function automatic logic pin_route(input logic [PIN_SEL_W-1:0] code,
                                     input logic [PIN_COUNT-1:0] pins,
                                     input periph_src_t src);
    logic r;
    logic [PIN_SEL_W-1:0] k;
    r = 1'h0;
    k = 7'h00;
    if (code <= PS_PIN_LAST) begin
      r = pins[5'(code)];
    end else if (code <= PS_DATA_LAST) begin
      k = code - PS_DATA_FIRST;
      r = k[0] ? src.sport_chan_b[3'(k >> 1)] : src.sport_chan_a[3'(k >> 1)];
    end else if (code <= PS_CLK_LAST) begin
      r = src.sport_clock[3'(code - PS_CLK_FIRST)];
    end else if (code <= PS_FS_LAST) begin
      r = src.sport_fs[3'(code - PS_FS_FIRST)];
    end else if (code <= PS_TIMER_LAST) begin
      r = src.gp_counter[2'(code - PS_TIMER_FIRST)];
    end else if (code >= PS_FLAG11_FIRST && code <= PS_FLAG11_LAST) begin
      r = src.general_flag[3'(code - PS_FLAG11_FIRST) + 3'h1];
    end else if (code >= PS_SRC_FIRST && code <= PS_SRC_LAST) begin
      r = src.rate_converter_data[2'(code - PS_SRC_FIRST)];
    end else if (code >= PS_SPI_SEL_FIRST && code <= PS_SPI_SEL_LAST) begin
      r = src.second_spi_select[2'(code - PS_SPI_SEL_FIRST)];
    end else begin
      case (code)
        PS_FLAG10: r = src.general_flag[0];
        PS_PDAP_STROBE: r = src.parallel_port_request_strobe;
        PS_PCG_CLK_A: r = src.precision_clock[0];
        PS_PCG_CLK_B: r = src.precision_clock[1];
        PS_PCG_FS_A: r = src.precision_framesync[0];
        PS_PCG_FS_B: r = src.precision_framesync[1];
        PS_FLAG15: r = src.general_flag[5];
        PS_RX_DATA: r = src.spdif_rx_data;
        PS_RX_FS: r = src.spdif_rx_framesync;
        PS_RX_CLK: r = src.spdif_rx_clock;
        PS_RX_TDM_CLK: r = src.spdif_rx_tdm_clock;
        PS_TX_BIPHASE: r = src.spdif_tx_biphase;
        PS_SPI_MISO: r = src.second_spi_miso;
        PS_SPI_MOSI: r = src.second_spi_mosi;
        PS_SPI_CLK: r = src.second_spi_clock;
        PS_RX_LR_FB: r = src.spdif_rx_lr_feedback;
        PS_RX_LR_REF: r = src.spdif_rx_lr_reference;
        PS_LOW: r = 1'h0;
        PS_HIGH: r = 1'h1;
        default: r = 1'h0;
      endcase
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave: one wait-free ack cycle after each request.

  logic req;
  logic [ADDR_W-3:0] widx;
  assign req = wb_req.cyc && wb_req.stb && !s_q.ack;
  assign widx = wb_req.adr[ADDR_W-1:2];

  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.rdata = 32'h00000000;
    for (int i = 0; i < FS_REGS; i++) begin
      if (widx == 6'(FS_SEL_BASE[ADDR_W-1:2] + 6'(i))) begin
        s_d.rdata = s_q.fs_word[i];
        if (req && wb_req.we) begin
          s_d.fs_word[i] = merge(s_q.fs_word[i], wb_req.dat, wb_req.sel, FS_WORD_MASK);
        end
      end
    end
    for (int i = 0; i < PIN_REGS; i++) begin
      if (widx == 6'(PIN_SEL_BASE[ADDR_W-1:2] + 6'(i))) begin
        s_d.rdata = s_q.pin_word[i];
        if (req && wb_req.we) begin
          s_d.pin_word[i] = merge(s_q.pin_word[i], wb_req.dat, wb_req.sel,
                                  (i == PIN_REGS - 1) ? PIN_LAST_WORD_MASK : PIN_WORD_MASK);
        end
      end
    end
    if (!req) begin
      s_d.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.fs_word <= {FS_REGS{FS_WORD_RESET}};
      s_q.pin_word <= {PIN_REGS{PIN_WORD_RESET}};
      s_q.ack <= 1'h0;
      s_q.rdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_rsp.ack = s_q.ack;
  assign wb_rsp.dat = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Routing is pure muxing so the routed edges keep their timing relation to
  // the source; the select words, inversion bits included, are the only registered part.

  logic inv19;
  logic inv20;
  logic [PIN_SEL_W-1:0] sel19;
  logic [PIN_SEL_W-1:0] sel20;
  assign inv19 = s_q.pin_word[PIN_REGS-1][INV_PIN19_BIT];
  assign inv20 = s_q.pin_word[PIN_REGS-1][INV_PIN20_BIT];
  assign sel19 = s_q.pin_word[(PIN_COUNT-2)/PIN_PER_WORD][((PIN_COUNT-2)%PIN_PER_WORD)*PIN_SEL_W +: PIN_SEL_W];
  assign sel20 = s_q.pin_word[(PIN_COUNT-1)/PIN_PER_WORD][((PIN_COUNT-1)%PIN_PER_WORD)*PIN_SEL_W +: PIN_SEL_W];

  always_comb begin
    for (int i = 0; i < FS_DESTS; i++) begin
      frame_sync_dest[i] = fs_route(s_q.fs_word[i/FS_PER_WORD][(i%FS_PER_WORD)*FS_SEL_W +: FS_SEL_W],
                                    pin_buffer_out, periph_src);
    end
    for (int i = 0; i < PIN_COUNT; i++) begin
      pin_buffer_in[i] = pin_route(s_q.pin_word[i/PIN_PER_WORD][(i%PIN_PER_WORD)*PIN_SEL_W +: PIN_SEL_W],
                                   pin_buffer_out, periph_src);
    end
    // A looped-back buffer would turn inversion into an oscillator, so it is blocked there.
    if (inv19 && sel19 != PS_PIN_LAST - 7'h01) begin
      pin_buffer_in[PIN_COUNT-2] = !pin_buffer_in[PIN_COUNT-2];
    end
    if (inv20 && sel20 != PS_PIN_LAST) begin
      pin_buffer_in[PIN_COUNT-1] = !pin_buffer_in[PIN_COUNT-1];
    end
  end

endmodule

/* shared/route_pkg.sv */
package route_pkg;

  localparam int FS_DESTS = 16;
  localparam int PIN_COUNT = 20;
  localparam int FS_SEL_W = 5;
  localparam int PIN_SEL_W = 7;
  localparam int FS_PER_WORD = 6;
  localparam int PIN_PER_WORD = 4;
  localparam int FS_REGS = (FS_DESTS + FS_PER_WORD - 1) / FS_PER_WORD;
  localparam int PIN_REGS = PIN_COUNT / PIN_PER_WORD;
  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] FS_SEL_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] PIN_SEL_BASE = 8'h10;

  // Inversion controls in the fifth pin select word.
  localparam int INV_PIN19_BIT = 28;
  localparam int INV_PIN20_BIT = 29;

  // Frame sync selection codes.
  localparam logic [FS_SEL_W-1:0] FS_PIN_LAST = 5'h13;
  localparam logic [FS_SEL_W-1:0] FS_SPORT_FIRST = 5'h14;
  localparam logic [FS_SEL_W-1:0] FS_SPORT_LAST = 5'h19;
  localparam logic [FS_SEL_W-1:0] FS_RX_FS = 5'h1A;
  localparam logic [FS_SEL_W-1:0] FS_TX_BIPHASE = 5'h1B;
  localparam logic [FS_SEL_W-1:0] FS_PCG_FS_A = 5'h1C;
  localparam logic [FS_SEL_W-1:0] FS_PCG_FS_B = 5'h1D;
  localparam logic [FS_SEL_W-1:0] FS_LOW = 5'h1E;
  localparam logic [FS_SEL_W-1:0] FS_HIGH = 5'h1F;

  // Pin selection codes.
  localparam logic [PIN_SEL_W-1:0] PS_PIN_LAST = 7'h13;
  localparam logic [PIN_SEL_W-1:0] PS_DATA_FIRST = 7'h14;
  localparam logic [PIN_SEL_W-1:0] PS_DATA_LAST = 7'h1F;
  localparam logic [PIN_SEL_W-1:0] PS_CLK_FIRST = 7'h20;
  localparam logic [PIN_SEL_W-1:0] PS_CLK_LAST = 7'h25;
  localparam logic [PIN_SEL_W-1:0] PS_FS_FIRST = 7'h26;
  localparam logic [PIN_SEL_W-1:0] PS_FS_LAST = 7'h2B;
  localparam logic [PIN_SEL_W-1:0] PS_TIMER_FIRST = 7'h2C;
  localparam logic [PIN_SEL_W-1:0] PS_TIMER_LAST = 7'h2E;
  localparam logic [PIN_SEL_W-1:0] PS_FLAG10 = 7'h2F;
  localparam logic [PIN_SEL_W-1:0] PS_PDAP_STROBE = 7'h30;
  localparam logic [PIN_SEL_W-1:0] PS_FLAG11_FIRST = 7'h34;
  localparam logic [PIN_SEL_W-1:0] PS_FLAG11_LAST = 7'h37;
  localparam logic [PIN_SEL_W-1:0] PS_PCG_CLK_A = 7'h38;
  localparam logic [PIN_SEL_W-1:0] PS_PCG_CLK_B = 7'h39;
  localparam logic [PIN_SEL_W-1:0] PS_PCG_FS_A = 7'h3A;
  localparam logic [PIN_SEL_W-1:0] PS_PCG_FS_B = 7'h3B;
  localparam logic [PIN_SEL_W-1:0] PS_FLAG15 = 7'h3C;
  localparam logic [PIN_SEL_W-1:0] PS_SRC_FIRST = 7'h3D;
  localparam logic [PIN_SEL_W-1:0] PS_SRC_LAST = 7'h40;
  localparam logic [PIN_SEL_W-1:0] PS_RX_DATA = 7'h41;
  localparam logic [PIN_SEL_W-1:0] PS_RX_FS = 7'h42;
  localparam logic [PIN_SEL_W-1:0] PS_RX_CLK = 7'h43;
  localparam logic [PIN_SEL_W-1:0] PS_RX_TDM_CLK = 7'h44;
  localparam logic [PIN_SEL_W-1:0] PS_TX_BIPHASE = 7'h45;
  localparam logic [PIN_SEL_W-1:0] PS_SPI_MISO = 7'h46;
  localparam logic [PIN_SEL_W-1:0] PS_SPI_MOSI = 7'h47;
  localparam logic [PIN_SEL_W-1:0] PS_SPI_CLK = 7'h48;
  localparam logic [PIN_SEL_W-1:0] PS_SPI_SEL_FIRST = 7'h49;
  localparam logic [PIN_SEL_W-1:0] PS_SPI_SEL_LAST = 7'h4C;
  localparam logic [PIN_SEL_W-1:0] PS_RX_LR_FB = 7'h4D;
  localparam logic [PIN_SEL_W-1:0] PS_RX_LR_REF = 7'h4E;
  localparam logic [PIN_SEL_W-1:0] PS_LOW = 7'h50;
  localparam logic [PIN_SEL_W-1:0] PS_HIGH = 7'h51;

  // Reset values: every route parks at logic low.
  localparam logic [31:0] FS_WORD_RESET = {2'h0, {6{5'h1E}}};
  localparam logic [31:0] PIN_WORD_RESET = {4'h0, {4{7'h50}}};
  localparam logic [31:0] FS_WORD_MASK = 32'h3FFFFFFF;
  localparam logic [31:0] PIN_WORD_MASK = 32'h0FFFFFFF;
  localparam logic [31:0] PIN_LAST_WORD_MASK = 32'h3FFFFFFF;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [5:0] sport_fs;
    logic [5:0] sport_chan_a;
    logic [5:0] sport_chan_b;
    logic [5:0] sport_clock;
    logic [2:0] gp_counter;
    logic [5:0] general_flag;
    logic parallel_port_request_strobe;
    logic [1:0] precision_clock;
    logic [1:0] precision_framesync;
    logic [3:0] rate_converter_data;
    logic spdif_rx_framesync;
    logic spdif_rx_clock;
    logic spdif_rx_tdm_clock;
    logic spdif_rx_data;
    logic spdif_tx_biphase;
    logic second_spi_miso;
    logic second_spi_mosi;
    logic second_spi_clock;
    logic [3:0] second_spi_select;
    logic spdif_rx_lr_feedback;
    logic spdif_rx_lr_reference;
  } periph_src_t;

endpackage

/* verification/far_side_model.sv */
module far_side_model (
  input wire logic sys_clk,
  input wire logic hold,
  output route_pkg::periph_src_t periph_src,
  output logic [route_pkg::PIN_COUNT-1:0] pin_buffer_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import route_pkg::*;
  localparam int SRC_W = $bits(periph_src_t);
  initial begin
    periph_src = '0;
    pin_buffer_out = '0;
  end
  // Sources change every cycle unless hold is set, so a wrong or stale route cannot match by luck for long.
  always @(posedge sys_clk) if (!hold) begin
    periph_src <= periph_src_t'(SRC_W'({$urandom, $urandom}));
    pin_buffer_out <= 20'($urandom);
  end
endmodule

/* verification/route_checker_props.sv */
module route_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire route_pkg::wb_req_t wb_req,
  input wire route_pkg::wb_rsp_t wb_rsp,
  input wire logic [route_pkg::PIN_COUNT-1:0] pin_buffer_out,
  input wire route_pkg::periph_src_t periph_src,
  input wire logic [route_pkg::FS_DESTS-1:0] frame_sync_dest,
  input wire logic [route_pkg::PIN_COUNT-1:0] pin_buffer_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import route_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_ack_next: assert property (
    wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack) else $error("ack late");
  a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held");
  a_ack_cause: assert property (
    wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb)) else $error("ack without request");
  a_idle_dat: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0) else $error("data without ack");
  a_unmapped_rd: assert property (wb_rsp.ack && $past(!wb_req.we &&
    (wb_req.adr == 8'h0C || wb_req.adr >= 8'h24)) |-> wb_rsp.dat == 32'h0) else $error("unmapped read");
  a_reset_quiet: assert property ($rose(resetn) |->
    !wb_rsp.ack && frame_sync_dest == '0 && pin_buffer_in == '0) else $error("not low after reset");
  a_route_stable: assert property ($stable(pin_buffer_out) && $stable(periph_src) &&
    !wb_rsp.ack |-> $stable(frame_sync_dest) && $stable(pin_buffer_in)) else $error("route moved");
  a_fs_high: assert property (wb_rsp.ack && $past(wb_req.we && wb_req.adr == 8'h00 &&
    wb_req.sel[0] && wb_req.dat[4:0] == 5'h1F) |-> frame_sync_dest[0]) else $error("high code");
endmodule
bind signal_routing_crossbar route_checker route_checker_inst (.sys_clk(sys_clk), .resetn(resetn),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .pin_buffer_out(pin_buffer_out), .periph_src(periph_src),
  .frame_sync_dest(frame_sync_dest), .pin_buffer_in(pin_buffer_in));

/* verification/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import route_pkg::*;
  logic sys_clk = 1'h0, resetn = 1'h0, hold = 1'h0;
  wb_req_t wb_req = '0;
  wb_rsp_t wb_rsp;
  logic [19:0] pin_buffer_out, pin_buffer_in;
  periph_src_t periph_src;
  logic [15:0] frame_sync_dest;
  logic [4:0] fs_sel [16];
  logic [6:0] pin_sel [20];
  logic [1:0] inv = 2'h0;
  logic [31:0] word [64];
  logic [31:0] w;
  logic [7:0] a;
  int miscompares = 0, comparisons = 0, cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  signal_routing_crossbar signal_routing_crossbar_inst (.sys_clk(sys_clk), .resetn(resetn), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .pin_buffer_out(pin_buffer_out), .periph_src(periph_src),
    .frame_sync_dest(frame_sync_dest), .pin_buffer_in(pin_buffer_in));
  far_side_model far_side_model_inst (.sys_clk(sys_clk), .hold(hold), .periph_src(periph_src),
    .pin_buffer_out(pin_buffer_out));
  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  function automatic logic fs_exp(input logic [4:0] c);
    if (c <= 5'h13) return pin_buffer_out[c];
    if (c <= 5'h19) return periph_src.sport_fs[c - 5'h14];
    return 1'({2'h2, periph_src.precision_framesync, periph_src.spdif_tx_biphase,
      periph_src.spdif_rx_framesync} >> (c - 5'h1A));
  endfunction
  function automatic logic pin_exp(input logic [6:0] c);
    periph_src_t s;
    s = periph_src;
    if (c <= 7'h13) return pin_buffer_out[c];
    if (c <= 7'h1F) return c[0] ? s.sport_chan_b[(c - 7'h14) >> 1] : s.sport_chan_a[(c - 7'h14) >> 1];
    if (c <= 7'h25) return s.sport_clock[c - 7'h20];
    if (c <= 7'h2B) return s.sport_fs[c - 7'h26];
    if (c <= 7'h2E) return s.gp_counter[c - 7'h2C];
    if (c <= 7'h30) return c[0] ? s.general_flag[0] : s.parallel_port_request_strobe;
    if (c <= 7'h33) return 1'b0;
    if (c <= 7'h37) return s.general_flag[c - 7'h33];
    if (c <= 7'h3B) return 1'({s.precision_framesync, s.precision_clock} >> (c - 7'h38));
    if (c == 7'h3C) return s.general_flag[5];
    if (c <= 7'h40) return s.rate_converter_data[c - 7'h3D];
    if (c <= 7'h4E) return 1'({s.spdif_rx_lr_reference, s.spdif_rx_lr_feedback, s.second_spi_select,
      s.second_spi_clock, s.second_spi_mosi, s.second_spi_miso, s.spdif_tx_biphase, s.spdif_rx_tdm_clock,
      s.spdif_rx_clock, s.spdif_rx_framesync, s.spdif_rx_data} >> (c - 7'h41));
    return c == 7'h51;
  endfunction
  // The selects are unpacked from a shadow of whole words so that byte-lane writes stay modelled.
  task automatic derive();
    for (int i = 0; i < 16; i++) fs_sel[i] = word[i / 6][5 * (i % 6) +: 5];
    for (int i = 0; i < 20; i++) pin_sel[i] = word[4 + i / 4][7 * (i % 4) +: 7];
    inv = word[8][29:28];
  endtask
  task automatic reset_shadow();
    foreach (word[i]) word[i] = i < 3 ? FS_WORD_RESET : (i > 3 && i < 9 ? PIN_WORD_RESET : 32'h0);
    derive();
  endtask
  task automatic xfer(input logic we, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] be,
      output logic [31:0] r);
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: ad, sel: be, dat: d};
    @(posedge sys_clk);
    while (wb_rsp.ack !== 1'h1) @(posedge sys_clk);
    r = wb_rsp.dat;
    wb_req <= '0;
    if (we) for (int b = 0; b < 4; b++) if (be[b]) word[ad[7:2]][b * 8 +: 8] = d[b * 8 +: 8];
    derive();
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'h1, ad, d, 4'hF, r);
  endtask
  task automatic wrb(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    xfer(1'h1, ad, d, be, r);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'h0, ad, 32'h0, 4'hF, r);
    chk(e, r);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge sys_clk) if (++cycles == 20000) begin
    miscompares++;
    end_of_test();
  end
  // Routes are only judged between bus cycles, when the shadow selects are known to be current.
  always @(negedge sys_clk) if (resetn && !wb_req.cyc) begin
    for (int n = 0; n < 16; n++) chk(fs_exp(fs_sel[n]), frame_sync_dest[n]);
    for (int n = 0; n < 20; n++) chk(pin_exp(pin_sel[n]) ^ (n == 18 && inv[0] && pin_sel[18] != 7'h12) ^
      (n == 19 && inv[1] && pin_sel[19] != 7'h13), pin_buffer_in[n]);
  end
  initial begin
    void'($urandom(32'h2cb8));
    reset_shadow();
    repeat (16) @(posedge sys_clk);
    resetn <= 1'h1;
    rd(8'h00, FS_WORD_RESET);
    rd(8'h10, PIN_WORD_RESET);
    for (int c = 0; c < 32; c++) begin
      w = $urandom;
      w[4:0] = 5'(c);
      a = 8'((c >> 3) % 3 * 4);
      wr(a, w);
      rd(a, w & FS_WORD_MASK);
      repeat (4) @(posedge sys_clk);
    end
    for (int c = 0; c < 128; c++) begin
      w = $urandom;
      w[6:0] = 7'(c);
      a = 8'h10 + 8'((c >> 4) % 5 * 4);
      wr(a, w);
      rd(a, w & (a == 8'h20 ? PIN_LAST_WORD_MASK : PIN_WORD_MASK));
      repeat (2) @(posedge sys_clk);
    end
    hold <= 1'h1;
    for (int k = 0; k < 2; k++) begin
      wr(8'h20, k ? {4'h3, 7'h12, 7'h13, 14'h0} : {4'h3, 7'h13, 7'h12, 14'h0});
      repeat (6) @(posedge sys_clk);
    end
    hold <= 1'h0;
    for (int k = 0; k < 200; k++) wr(8'(($urandom % 11) * 4), $urandom);
    // Byte lanes merge on their own, so a partial write must leave the other fields alone.
    for (int k = 0; k < 40; k++) begin
      a = 8'((k % 8 + (k % 8 > 2 ? 1 : 0)) * 4);
      wrb(a, $urandom, 4'($urandom));
      rd(a, word[a[7:2]] & (a < 8'h0C ? FS_WORD_MASK : a == 8'h20 ? PIN_LAST_WORD_MASK : PIN_WORD_MASK));
    end
    // A reset in mid-run must bring every select and both inversions back to their parked values.
    resetn <= 1'h0;
    reset_shadow();
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    rd(8'h08, FS_WORD_RESET);
    rd(8'h20, PIN_WORD_RESET);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    rd(8'h0C, 32'h0);
    end_of_test();
  end
endmodule
